// ==== logic/cml_loader.sv ====
// Startup loader that reads the configuration memory and applies it.
`timescale 1ns/1ps

module cml_loader #(
  parameter int NUM_WORDS = cml_pkg::NUM_WORDS,
  parameter int ADDR_W    = cml_pkg::ADDR_W,
  parameter int WORD_W    = cml_pkg::WORD_W
) (
  input  wire logic              sys_clk,
  input  wire logic              reset,
  input  wire logic              usb_bus_reset,
  input  wire logic              ext_reset_n,
  output logic                   cfg_mem_select_o,
  output logic                   cfg_mem_select_oe_n,
  output logic                   cfg_mem_serial_clock_o,
  output logic                   cfg_mem_serial_clock_oe_n,
  input  wire logic              cfg_mem_data_io_i,
  output logic                   cfg_mem_data_io_o,
  output logic                   cfg_mem_data_io_oe_n,
  input  wire logic [ADDR_W-1:0] cfg_rd_addr,
  output logic [WORD_W-1:0]      cfg_rd_data,
  output cml_pkg::cml_mode_e     chan_a_mode,
  output cml_pkg::cml_mode_e     chan_b_mode,
  output logic                   mem_present,
  output logic                   cfg_valid,
  output logic                   cfg_ready
);

  typedef enum logic [2:0] {
    ST_HOLD  = 3'b000,
    ST_ISSUE = 3'b001,
    ST_WAIT  = 3'b010,
    ST_CHECK = 3'b011,
    ST_DONE  = 3'b100
  } cml_state_e;

  cml_state_e         st_reg;
  logic               ext_meta_reg;
  logic               ext_sync_reg;
  logic               tristate_reg;
  logic [ADDR_W-1:0]  word_reg;
  logic [WORD_W-1:0]  sum_reg;
  logic [WORD_W-1:0]  mem_words [NUM_WORDS];
  logic               present_reg;
  logic               valid_reg;
  logic               ready_reg;
  cml_pkg::cml_mode_e mode_a_reg;
  cml_pkg::cml_mode_e mode_b_reg;
  logic [WORD_W-1:0]  rd_data_reg;
  logic               hold;
  logic               restart;
  logic               port_sel;
  logic               port_sclk;
  logic               port_data;
  logic               port_drive;
  logic               port_done;
  logic               port_ack;
  logic [WORD_W-1:0]  port_word;
  logic               sum_ok;

  // Decodes a channel mode field; the spare code falls back to UART.
  function automatic cml_pkg::cml_mode_e mode_of(
    input logic [WORD_W-1:0] word,
    input int                lsb
  );
    logic [1:0] code;
    code = word[lsb +: 2];
    case (code)
      cml_pkg::MODE_FIFO: mode_of = cml_pkg::MODE_FIFO;
      cml_pkg::MODE_OPTO: mode_of = cml_pkg::MODE_OPTO;
      default:            mode_of = cml_pkg::MODE_UART;
    endcase
  endfunction

  // ==========================================================================
  // External reset pin synchroniser and pin release.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ext_meta_reg <= 1'b0;
      ext_sync_reg <= 1'b0;
    end else begin
      ext_meta_reg <= ext_reset_n;
      ext_sync_reg <= ext_meta_reg;
    end
  end

  assign hold    = !ext_sync_reg;
  assign restart = hold || usb_bus_reset;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      tristate_reg <= 1'b1;
    end else begin
      tristate_reg <= hold;
    end
  end

  // ==========================================================================
  // Serial engine.
  cml_serial_port #(
    .ADDR_W   (ADDR_W),
    .WORD_W   (WORD_W),
    .HALF_CYC (cml_pkg::SK_HALF_CYC)
  ) i_cml_serial_port (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .abort     (restart),
    .start     (st_reg == ST_ISSUE),
    .addr      (word_reg),
    .data_i    (cfg_mem_data_io_i),
    .sel_o     (port_sel),
    .sclk_o    (port_sclk),
    .data_o    (port_data),
    .drive_o   (port_drive),
    .done_o    (port_done),
    .ack_ok_o  (port_ack),
    .rd_data_o (port_word)
  );

  assign cfg_mem_select_o          = port_sel;
  assign cfg_mem_select_oe_n       = tristate_reg;
  assign cfg_mem_serial_clock_o    = port_sclk;
  assign cfg_mem_serial_clock_oe_n = tristate_reg;
  assign cfg_mem_data_io_o         = port_data;
  assign cfg_mem_data_io_oe_n      = tristate_reg || !port_drive;

  // ==========================================================================
  // Scan sequence.
  always_ff @(posedge sys_clk) begin
    if (reset || restart) begin
      st_reg <= ST_HOLD;
    end else begin
      unique case (st_reg)
        ST_HOLD:  st_reg <= ST_ISSUE;
        ST_ISSUE: st_reg <= ST_WAIT;
        ST_WAIT: begin
          if (port_done && !port_ack) begin
            st_reg <= ST_DONE;
          end else if (port_done && word_reg == ADDR_W'(NUM_WORDS - 1)) begin
            st_reg <= ST_CHECK;
          end else if (port_done) begin
            st_reg <= ST_ISSUE;
          end
        end
        ST_CHECK: st_reg <= ST_DONE;
        ST_DONE:  st_reg <= ST_DONE;
        default:  st_reg <= ST_HOLD;
      endcase
    end
  end

  // ==========================================================================
  // Word capture and running checksum.
  always_ff @(posedge sys_clk) begin
    if (reset || st_reg == ST_HOLD) begin
      word_reg <= '0;
      sum_reg  <= cml_pkg::CHK_SEED;
    end else if (st_reg == ST_WAIT && port_done && port_ack) begin
      mem_words[word_reg] <= port_word;
      if (word_reg != ADDR_W'(NUM_WORDS - 1)) begin
        sum_reg  <= sum_reg + port_word;
        word_reg <= word_reg + ADDR_W'(1);
      end
    end
  end

  assign sum_ok = sum_reg == mem_words[NUM_WORDS - 1];

  always_ff @(posedge sys_clk) begin
    rd_data_reg <= mem_words[cfg_rd_addr];
  end

  // ==========================================================================
  // Applied configuration.
  always_ff @(posedge sys_clk) begin
    if (reset || restart) begin
      present_reg <= 1'b0;
      valid_reg   <= 1'b0;
      ready_reg   <= 1'b0;
      mode_a_reg  <= cml_pkg::MODE_UART;
      mode_b_reg  <= cml_pkg::MODE_UART;
    end else if (st_reg == ST_WAIT && port_done && !port_ack) begin
      present_reg <= 1'b0;
      ready_reg   <= 1'b1;
      mode_a_reg  <= cml_pkg::MODE_UART;
      mode_b_reg  <= cml_pkg::MODE_UART;
    end else if (st_reg == ST_CHECK) begin
      present_reg <= 1'b1;
      valid_reg   <= sum_ok;
      ready_reg   <= 1'b1;
      if (sum_ok) begin
        mode_a_reg <= mode_of(mem_words[cml_pkg::MODE_WORD_IDX],
                              cml_pkg::CHA_MODE_LSB);
        mode_b_reg <= mode_of(mem_words[cml_pkg::MODE_WORD_IDX],
                              cml_pkg::CHB_MODE_LSB);
      end else begin
        mode_a_reg <= cml_pkg::MODE_UART;
        mode_b_reg <= cml_pkg::MODE_UART;
      end
    end
  end

  assign cfg_rd_data = rd_data_reg;
  assign chan_a_mode = mode_a_reg;
  assign chan_b_mode = mode_b_reg;
  assign mem_present = present_reg;
  assign cfg_valid   = valid_reg;
  assign cfg_ready   = ready_reg;

  // ==========================================================================
  // Checks.
  a_hold_tristate: assert property (@(posedge sys_clk)
    disable iff (reset)
    hold |=> (cfg_mem_select_oe_n && cfg_mem_serial_clock_oe_n
              && cfg_mem_data_io_oe_n))
    else $error("Memory pins driven while held in reset.");

  a_release_scan: assert property (@(posedge sys_clk)
    disable iff (reset)
    (st_reg == ST_HOLD && !restart) |=>
      st_reg == ST_ISSUE ##1 st_reg == ST_WAIT)
    else $error("Scan did not start after reset release.");

  a_usb_rescan: assert property (@(posedge sys_clk) disable iff (reset)
    usb_bus_reset |=> (st_reg == ST_HOLD && !cfg_ready))
    else $error("Bus reset did not restart the scan.");

  a_default_uart: assert property (@(posedge sys_clk) disable iff (reset)
    (cfg_ready && !cfg_valid) |-> (chan_a_mode == cml_pkg::MODE_UART
                                   && chan_b_mode == cml_pkg::MODE_UART))
    else $error("Defaults not in UART mode.");

  a_valid_present: assert property (@(posedge sys_clk)
    disable iff (reset)
    cfg_valid |-> (mem_present && cfg_ready))
    else $error("Valid configuration without a memory.");

  a_nack_absent: assert property (@(posedge sys_clk) disable iff (reset)
    (st_reg == ST_WAIT && port_done && !port_ack && !restart)
      |=> (st_reg == ST_DONE && !mem_present && cfg_ready))
    else $error("Missing acknowledge not treated as absent.");

  a_mode_memory: assert property (@(posedge sys_clk) disable iff (reset)
    (st_reg == ST_CHECK && sum_ok && !restart) |=>
      chan_a_mode == mode_of(mem_words[cml_pkg::MODE_WORD_IDX],
                             cml_pkg::CHA_MODE_LSB))
    else $error("Channel mode not taken from memory.");

  a_check_sum: assert property (@(posedge sys_clk) disable iff (reset)
    (st_reg == ST_CHECK && !restart) |=> cfg_valid == $past(sum_ok))
    else $error("Validity does not follow the checksum.");

endmodule

// ==== common/cml_pkg.sv ====
// Shared constants for the configuration memory loader.
package cml_pkg;

  // ==========================================================================
  // Clocking of the serial memory link.
  localparam int SYS_CLK_KHZ = 25000;
  localparam int SK_RATE_KHZ = 1000;
  localparam int SK_HALF_CYC =
    (SYS_CLK_KHZ + 2 * SK_RATE_KHZ - 1) / (2 * SK_RATE_KHZ);

  // ==========================================================================
  // Memory geometry and read command.
  localparam int WORD_W    = 16;
  localparam int ADDR_W    = 6;
  localparam int NUM_WORDS = 64;
  localparam int CMD_BITS  = 3;
  localparam logic [CMD_BITS-1:0] CMD_READ = 3'h6;

  // ==========================================================================
  // Configuration word layout and integrity check.
  localparam int MODE_WORD_IDX = 0;
  localparam int CHA_MODE_LSB  = 0;
  localparam int CHB_MODE_LSB  = 2;
  localparam logic [WORD_W-1:0] CHK_SEED = 16'hAAAA;

  // ==========================================================================
  // Channel interface modes.
  typedef enum logic [1:0] {
    MODE_UART = 2'b00,
    MODE_FIFO = 2'b01,
    MODE_OPTO = 2'b10
  } cml_mode_e;

endpackage

// ==== logic/cml_serial_port.sv ====
// Three-wire serial engine that reads one word from the memory.
`timescale 1ns/1ps
module cml_serial_port #(
  parameter int ADDR_W   = cml_pkg::ADDR_W,
  parameter int WORD_W   = cml_pkg::WORD_W,
  parameter int HALF_CYC = cml_pkg::SK_HALF_CYC
) (
  input  wire logic              sys_clk,
  input  wire logic              reset,
  input  wire logic              abort,
  input  wire logic              start,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic              data_i,
  output logic                   sel_o,
  output logic                   sclk_o,
  output logic                   data_o,
  output logic                   drive_o,
  output logic                   done_o,
  output logic                   ack_ok_o,
  output logic [WORD_W-1:0]      rd_data_o
);

  localparam int CW   = cml_pkg::CMD_BITS + ADDR_W;
  localparam int LAST = CW + WORD_W;
  localparam int BW   = $clog2(LAST + 1);
  localparam int DW   = $clog2(HALF_CYC + 1);

  logic              busy_reg;
  logic              sk_reg;
  logic [DW-1:0]     div_reg;
  logic [BW-1:0]     bit_reg;
  logic [CW-1:0]     cmd_reg;
  logic              drive_reg;
  logic              done_reg;
  logic              ack_reg;
  logic [WORD_W-1:0] shift_reg;
  logic              d_meta_reg;
  logic              d_sync_reg;
  logic              tick;

  assign tick = busy_reg && (div_reg == DW'(HALF_CYC - 1));

  // ==========================================================================
  // Input synchroniser for the shared data line.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      d_meta_reg <= 1'b1;
      d_sync_reg <= 1'b1;
    end else begin
      d_meta_reg <= data_i;
      d_sync_reg <= d_meta_reg;
    end
  end

  // ==========================================================================
  // Frame sequencing and command shifting.
  always_ff @(posedge sys_clk) begin
    if (reset || abort) begin
      busy_reg  <= 1'b0;
      sk_reg    <= 1'b0;
      div_reg   <= '0;
      bit_reg   <= '0;
      cmd_reg   <= '0;
      drive_reg <= 1'b0;
      done_reg  <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      if (!busy_reg && start) begin
        busy_reg  <= 1'b1;
        sk_reg    <= 1'b0;
        div_reg   <= '0;
        bit_reg   <= '0;
        cmd_reg   <= {cml_pkg::CMD_READ, addr};
        drive_reg <= 1'b1;
      end else if (busy_reg) begin
        div_reg <= tick ? '0 : div_reg + DW'(1);
        if (tick) begin
          sk_reg <= ~sk_reg;
        end
        if (tick && sk_reg) begin
          cmd_reg <= {cmd_reg[CW-2:0], 1'b0};
          if (bit_reg == BW'(CW - 1)) begin
            drive_reg <= 1'b0;
          end
          if (bit_reg == BW'(LAST)) begin
            busy_reg <= 1'b0;
            done_reg <= 1'b1;
          end else begin
            bit_reg <= bit_reg + BW'(1);
          end
        end
      end
    end
  end

  // ==========================================================================
  // Acknowledge check and data capture on rising clock edges.
  always_ff @(posedge sys_clk) begin
    if (reset || (start && !busy_reg)) begin
      ack_reg   <= 1'b0;
      shift_reg <= '0;
    end else if (tick && !sk_reg) begin
      if (bit_reg == BW'(CW)) begin
        ack_reg <= ~d_sync_reg;
      end else if (bit_reg > BW'(CW)) begin
        shift_reg <= {shift_reg[WORD_W-2:0], d_sync_reg};
      end
    end
  end

  assign sel_o     = busy_reg;
  assign sclk_o    = sk_reg;
  assign data_o    = cmd_reg[CW-1];
  assign drive_o   = drive_reg;
  assign done_o    = done_reg;
  assign ack_ok_o  = ack_reg;
  assign rd_data_o = shift_reg;

  // ==========================================================================
  // Checks.
  a_data_released: assert property (@(posedge sys_clk)
    disable iff (reset)
    (tick && !sk_reg && bit_reg >= BW'(CW)) |-> !drive_reg)
    else $error("Data pin still driven while memory answers.");

endmodule

// ==== sim/cml_mem_model.sv ====
// Behavioural three-wire sixteen-bit configuration memory.
`timescale 1ns/1ps
module cml_mem_model (
  input  wire logic sel,
  input  wire logic sclk,
  input  wire logic din,
  input  wire logic present,
  output logic      dout_q,
  output logic      dout_en,
  output int        frames,
  output int        bad_cmd,
  output int        bad_order
);
  // ==========================================================================
  // Storage and frame state.
  logic [15:0] mem [0:63];
  logic [8:0]  cmd;
  int          cnt;

  initial begin
    cnt = 0;
    cmd = '0;
    dout_q = 1'b1;
    dout_en = 1'b0;
    frames = 0;
    bad_cmd = 0;
    bad_order = 0;
  end

  // ==========================================================================
  // Command bits are taken on rising serial clock edges.
  always @(posedge sclk or negedge sel) begin
    if (!sel) begin
      cnt <= 0;
    end else begin
      if (cnt < 9) begin
        cmd <= {cmd[7:0], din};
      end
      cnt <= cnt + 1;
    end
  end

  // ==========================================================================
  // Reply bits change on falling edges; an absent part never drives.
  always @(negedge sclk or negedge sel) begin
    if (!sel) begin
      dout_en <= 1'b0;
    end else if (cnt == 9 && present) begin
      if (cmd[8:6] !== cml_pkg::CMD_READ) begin
        bad_cmd <= bad_cmd + 1;
      end else begin
        if (int'(cmd[5:0]) != frames % 64) begin
          bad_order <= bad_order + 1;
        end
        frames <= frames + 1;
        dout_en <= 1'b1;
        dout_q <= 1'b0;
      end
    end else if (dout_en && cnt <= 25) begin
      dout_q <= mem[cmd[5:0]][25 - cnt];
    end else begin
      dout_en <= 1'b0;
    end
  end
endmodule

// ==== sim/test_cml_loader.sv ====
// Self-checking bench for the configuration memory loader.
`timescale 1ns/1ps
module test_cml_loader;
  // ==========================================================================
  // Signals.
  logic               sys_clk;
  logic               reset;
  logic               usb_bus_reset;
  logic               ext_reset_n;
  logic               present;
  logic [5:0]         cfg_rd_addr;
  logic [15:0]        cfg_rd_data;
  cml_pkg::cml_mode_e chan_a_mode;
  cml_pkg::cml_mode_e chan_b_mode;
  logic               mem_present;
  logic               cfg_valid;
  logic               cfg_ready;
  logic               sel_o;
  logic               sel_oe_n;
  logic               sk_o;
  logic               sk_oe_n;
  logic               d_o;
  logic               d_oe_n;
  logic               mem_q;
  logic               mem_en;
  logic               sel_w;
  logic               sk_w;
  logic               data_w;
  int                 frames;
  int                 bad_cmd;
  int                 bad_order;
  int                 error_cnt;
  int                 checks_done;
  logic [15:0]        img [0:63];

  // Released select and clock are parked low by the other master.
  assign sel_w = !sel_oe_n & sel_o;
  assign sk_w = !sk_oe_n & sk_o;
  // The data line has a pull-up; the loader wins over the memory.
  assign data_w = !d_oe_n ? d_o : (mem_en ? mem_q : 1'b1);

  cml_loader i_cml_loader (
    .sys_clk                   (sys_clk),
    .reset                     (reset),
    .usb_bus_reset             (usb_bus_reset),
    .ext_reset_n               (ext_reset_n),
    .cfg_mem_select_o          (sel_o),
    .cfg_mem_select_oe_n       (sel_oe_n),
    .cfg_mem_serial_clock_o    (sk_o),
    .cfg_mem_serial_clock_oe_n (sk_oe_n),
    .cfg_mem_data_io_i         (data_w),
    .cfg_mem_data_io_o         (d_o),
    .cfg_mem_data_io_oe_n      (d_oe_n),
    .cfg_rd_addr               (cfg_rd_addr),
    .cfg_rd_data               (cfg_rd_data),
    .chan_a_mode               (chan_a_mode),
    .chan_b_mode               (chan_b_mode),
    .mem_present               (mem_present),
    .cfg_valid                 (cfg_valid),
    .cfg_ready                 (cfg_ready)
  );

  cml_mem_model i_cml_mem_model (
    .sel       (sel_w),
    .sclk      (sk_w),
    .din       (data_w),
    .present   (present),
    .dout_q    (mem_q),
    .dout_en   (mem_en),
    .frames    (frames),
    .bad_cmd   (bad_cmd),
    .bad_order (bad_order)
  );

  // ==========================================================================
  // Shared tasks.
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    if (error_cnt == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic wait_ready();
    int n;
    n = 0;
    while (cfg_ready !== 1'b1 && n < 50000) begin
      @(negedge sys_clk);
      n++;
    end
    check(16'(cfg_ready), 16'h0001);
  endtask

  task automatic check_modes(input logic [1:0] a, input logic [1:0] b);
    check(16'(chan_a_mode), 16'(a));
    check(16'(chan_b_mode), 16'(b));
  endtask

  task automatic load_image(input logic [15:0] flip);
    logic [15:0] sum;
    sum = cml_pkg::CHK_SEED;
    for (int k = 0; k < 63; k++) begin
      img[k] = (k == 0) ? 16'h0009 : 16'h5a00 + 16'(k * 3);
      sum = sum + img[k];
    end
    img[63] = sum ^ flip;
    for (int k = 0; k < 64; k++) begin
      i_cml_mem_model.mem[k] = img[k];
    end
  endtask

  // ==========================================================================
  // Scenarios.
  task automatic test_hold_and_load();
    int addrs [5];
    addrs = '{0, 1, 31, 62, 63};
    repeat (10) @(negedge sys_clk);
    check({13'h0000, sel_oe_n, sk_oe_n, d_oe_n}, 16'h0007);
    check(16'(cfg_ready), 16'h0000);
    load_image(16'h0000);
    ext_reset_n = 1'b1;
    wait_ready();
    check(16'(mem_present), 16'h0001);
    check(16'(cfg_valid), 16'h0001);
    check_modes(2'b01, 2'b10);
    check(16'(frames), 16'h0040);
    check(16'(bad_cmd + bad_order), 16'h0000);
    foreach (addrs[i]) begin
      cfg_rd_addr = 6'(addrs[i]);
      repeat (2) @(negedge sys_clk);
      check(cfg_rd_data, img[addrs[i]]);
    end
  endtask

  task automatic test_bad_checksum();
    load_image(16'h0001);
    usb_bus_reset = 1'b1;
    @(negedge sys_clk);
    usb_bus_reset = 1'b0;
    check(16'(cfg_ready), 16'h0000);
    wait_ready();
    check(16'(mem_present), 16'h0001);
    check(16'(cfg_valid), 16'h0000);
    check_modes(2'b00, 2'b00);
    check(16'(frames), 16'h0080);
  endtask

  task automatic test_absent();
    ext_reset_n = 1'b0;
    present = 1'b0;
    repeat (6) @(negedge sys_clk);
    check({13'h0000, sel_oe_n, sk_oe_n, d_oe_n}, 16'h0007);
    ext_reset_n = 1'b1;
    wait_ready();
    check(16'(mem_present), 16'h0000);
    check(16'(cfg_valid), 16'h0000);
    check_modes(2'b00, 2'b00);
    check(16'(frames), 16'h0080);
  endtask

  // ==========================================================================
  // Clock, watchdog and main sequence.
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  initial begin
    #4400000;
    error_cnt++;
    wrap_up();
  end

  initial begin
    error_cnt = 0;
    checks_done = 0;
    reset = 1'b1;
    usb_bus_reset = 1'b0;
    ext_reset_n = 1'b0;
    present = 1'b1;
    cfg_rd_addr = 6'h00;
    repeat (2) @(negedge sys_clk);
    check({13'h0000, sel_oe_n, sk_oe_n, d_oe_n}, 16'h0007);
    reset = 1'b0;
    test_hold_and_load();
    test_bad_checksum();
    test_absent();
    wrap_up();
  end
endmodule
